/* logic/adfr_top.sv */
/*
 * Digital sequencer of a push-pull start-up controller: alternating
 * drive, sync during discharge, over-current off period and soft start.
 * Assumes discharge_phase_in, over_current_in and supply_lockout_in are
 * synchronous to clk_in and that the oscillator keeps running in faults.
 */
// Overview of operation
// - Sync stays low during the off period, while fault_off_out is high.
// - While active, sync is high in the discharge phase, low otherwise.
// - Sync never overlaps a high drive output.
// - Successive pulses go alternately to phase A and phase B.
// - A high current sense comparator starts a shutdown.
// - The first pulse after a start or retry comes 57 to 62 cycles later.
// - Soft start lasts 4 to 7 output cycles up to the first full pulse.
// - Soft start moves the leading edge earlier with a fixed trailing edge.
// - After a fault the outputs stay off for at least 56 cycles.
// - The whole recovery takes 64 oscillator cycles.
// - Sync pulses resume at least one cycle before the first drive pulse.
// - Over-current removes the drive pulses at once, mid cycle.
// - A toggle advanced once per cycle picks the output for each pulse.
`timescale 1ns/1ps
module adfr_top (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Supply, sense and oscillator phase
    input  wire logic supply_lockout_in,
    input  wire logic over_current_in,
    input  wire logic discharge_phase_in,
    // Gate drives and sync
    output logic      drive_phase_a_out,
    output logic      drive_phase_b_out,
    output logic      sync_out,
    output logic      fault_off_out
);

    adfr_ramp_if rif ();

    logic                  disch_prev_q;
    logic [6:0]            rec_q;
    logic [6:0]            rec_d;
    logic [15:0]           pos_q;
    logic [15:0]           len_q;
    logic                  toggle_q;
    logic                  drive_a_q;
    logic                  drive_b_q;
    logic                  sync_q;
    logic                  last_a_q;
    logic                  disch_rise;
    logic                  shutdown;
    logic                  switching;
    logic                  allow;
    logic                  drive_on;
    adfr_pkg::adfr_state_t st;

    function automatic adfr_pkg::adfr_state_t state_of(
        input logic [6:0] rec
    );
        if (rec < adfr_pkg::OFF_CYCLES) begin
            return adfr_pkg::ADFR_OFF;
        end else if (rec < adfr_pkg::SOFT_START) begin
            return adfr_pkg::ADFR_LEAD;
        end else if (rec < adfr_pkg::RUN_AT) begin
            return adfr_pkg::ADFR_SOFT;
        end
        return adfr_pkg::ADFR_RUN;
    endfunction : state_of

    // Each rising edge of the discharge phase ends one oscillator cycle.
    assign disch_rise = discharge_phase_in && !disch_prev_q;
    assign shutdown   = over_current_in || supply_lockout_in;
    assign st         = state_of(rec_q);
    assign switching  = (st == adfr_pkg::ADFR_SOFT) ||
                        (st == adfr_pkg::ADFR_RUN);

    // Recovery counter: cleared by a fault, saturates when running.
    assign rec_d = shutdown ? adfr_pkg::REC_RESET :
                   (disch_rise && rec_q < adfr_pkg::RUN_AT) ?
                   rec_q + 7'h01 : rec_q;

    assign rif.charge_len = len_q;
    assign rif.position   = pos_q;
    assign rif.step = (st == adfr_pkg::ADFR_SOFT) ?
                      3'(rec_q - adfr_pkg::SOFT_BASE) :
                      adfr_pkg::STEP_NONE;

    adfr_ramp u_ramp (
        .rif (rif.ramp)
    );

    always_comb begin
        case (st)
            adfr_pkg::ADFR_SOFT: begin
                allow = rif.allow;
            end
            adfr_pkg::ADFR_RUN: begin
                allow = 1'b1;
            end
            default: begin
                allow = 1'b0;
            end
        endcase
    end

    // Drive pulses only in the charge phase, which leaves the discharge
    // phase as dead time for the sync pulse.
    assign drive_on = switching && !discharge_phase_in && allow &&
                      !shutdown;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            // Starting high keeps a phase already high at release uncounted.
            disch_prev_q <= 1'b1;
            rec_q        <= adfr_pkg::REC_RESET;
        end else begin
            disch_prev_q <= discharge_phase_in;
            rec_q        <= rec_d;
        end
    end

    // Charge phase length, used to place the soft start leading edge.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pos_q <= adfr_pkg::LEN_RESET;
            len_q <= adfr_pkg::LEN_RESET;
        end else begin
            if (discharge_phase_in) begin
                pos_q <= adfr_pkg::LEN_RESET;
            end else if (pos_q != adfr_pkg::LEN_MAX) begin
                pos_q <= pos_q + 16'h0001;
            end
            if (disch_rise) begin
                len_q <= pos_q;
            end
        end
    end

    // Toggle starts at phase A on every start and advances each cycle.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            toggle_q <= 1'b0;
        end else if (!switching || shutdown) begin
            toggle_q <= 1'b0;
        end else if (disch_rise) begin
            toggle_q <= !toggle_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            drive_a_q <= 1'b0;
            drive_b_q <= 1'b0;
            sync_q    <= 1'b0;
        end else begin
            drive_a_q <= drive_on && !toggle_q;
            drive_b_q <= drive_on && toggle_q;
            sync_q    <= (st != adfr_pkg::ADFR_OFF) && discharge_phase_in &&
                         !shutdown;
        end
    end

    // Gating by the fault itself removes a pulse without waiting a cycle.
    assign drive_phase_a_out = drive_a_q && !shutdown;
    assign drive_phase_b_out = drive_b_q && !shutdown;
    assign sync_out          = sync_q && !shutdown;
    assign fault_off_out     = (st == adfr_pkg::ADFR_OFF);

    // Helper for checking: which phase took the last pulse.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !switching) begin
            last_a_q <= 1'b0;
        end else if (drive_phase_a_out) begin
            last_a_q <= 1'b1;
        end else if (drive_phase_b_out) begin
            last_a_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sync_off_a:
        assert property ((st == adfr_pkg::ADFR_OFF) |-> !sync_out)
        else $error("sync high while outputs are inactive");

    sync_discharge_a:
        assert property ((st != adfr_pkg::ADFR_OFF) && discharge_phase_in
                         && !shutdown |=> sync_out || shutdown)
        else $error("sync missing during discharge phase");

    dead_time_a:
        assert property (!(sync_out &&
                           (drive_phase_a_out || drive_phase_b_out)))
        else $error("sync overlaps a drive pulse");

    alternate_a:
        assert property ($rose(drive_phase_a_out) |-> !last_a_q)
        else $error("phase A received two pulses in a row");

    alternate_b_a:
        assert property ($rose(drive_phase_b_out) |-> last_a_q)
        else $error("phase B received two pulses in a row");

    oc_shutdown_a:
        assert property (over_current_in |=> fault_off_out && rec_q == 7'h00)
        else $error("over-current did not start a shutdown");

    oc_immediate_a:
        assert property (over_current_in |->
                         !drive_phase_a_out && !drive_phase_b_out)
        else $error("drive high during over-current");

    first_pulse_a:
        assert property ((st != adfr_pkg::ADFR_RUN) &&
                         (drive_phase_a_out || drive_phase_b_out) |->
                         rec_q >= 7'h39 && rec_q <= 7'h3E)
        else $error("first pulse outside the start delay window");

    soft_span_a:
        assert property ((st == adfr_pkg::ADFR_SOFT) ##1
                         (st == adfr_pkg::ADFR_RUN) |->
                         $past(rec_q) == 7'h3E)
        else $error("soft start span wrong");

    trailing_edge_a:
        assert property ($fell(drive_phase_a_out || drive_phase_b_out) &&
                         !over_current_in && !$past(over_current_in) &&
                         !supply_lockout_in |-> $past(discharge_phase_in))
        else $error("pulse ended outside the discharge edge");

    off_period_a:
        assert property ((drive_phase_a_out || drive_phase_b_out) |->
                         rec_q > 7'h38)
        else $error("drive before the off period ended");

    run_at_64_a:
        assert property ($fell(discharge_phase_in) &&
                         (st == adfr_pkg::ADFR_RUN) && !shutdown |=>
                         drive_phase_a_out || drive_phase_b_out || shutdown)
        else $error("full width reached at wrong cycle");

    sync_lead_a:
        assert property ($rose(st == adfr_pkg::ADFR_SOFT) |->
                         $past(st) == adfr_pkg::ADFR_LEAD)
        else $error("soft start without leading sync cycles");

    lockout_off_a:
        assert property (supply_lockout_in |->
                         !drive_phase_a_out && !drive_phase_b_out &&
                         !sync_out)
        else $error("output active during supply lockout");

endmodule : adfr_top

/* logic/adfr_pkg.sv */
/*
 * Shared constants and types of the alternating driver with fault retry.
 * Assumes one 200 MHz clock and an oscillator phase level sampled on it.
 */
package adfr_pkg;

    // Oscillator cycles counted from the release of a fault or lockout.
    localparam logic [6:0]  REC_RESET  = 7'h00;
    localparam logic [6:0]  OFF_CYCLES = 7'h38;
    localparam logic [6:0]  SOFT_BASE  = 7'h39;
    localparam logic [6:0]  SOFT_START = 7'h3A;
    localparam logic [6:0]  RUN_AT     = 7'h3F;

    // Charge phase measurement in clock cycles.
    localparam int          LEN_W      = 16;
    localparam logic [15:0] LEN_RESET  = 16'h0000;
    localparam logic [15:0] LEN_MAX    = 16'hFFFF;

    // Soft start width is step eighths of the charge phase.
    localparam int          STEP_W     = 3;
    localparam int          STEP_SHIFT = 3;
    localparam logic [2:0]  STEP_NONE  = 3'h0;

    typedef enum logic [1:0] {
        ADFR_OFF,
        ADFR_LEAD,
        ADFR_SOFT,
        ADFR_RUN
    } adfr_state_t;

endpackage : adfr_pkg

/* logic/adfr_ramp_if.sv */
/*
 * Carrier between the sequencer and the soft start edge generator.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface adfr_ramp_if;
    logic [adfr_pkg::LEN_W-1:0]  charge_len;
    logic [adfr_pkg::LEN_W-1:0]  position;
    logic [adfr_pkg::STEP_W-1:0] step;
    logic                        allow;

    modport seq  (output charge_len, output position, output step,
                  input allow);
    modport ramp (input charge_len, input position, input step,
                  output allow);
endinterface : adfr_ramp_if

/* logic/adfr_ramp.sv */
/*
 * Soft start leading edge generator.
 * Assumes the sequencer supplies the last charge length, the position
 * inside the present charge phase and a step of one to five.
 */
`timescale 1ns/1ps
module adfr_ramp (
    // Sequencer side
    adfr_ramp_if.ramp rif
);

    logic [18:0] width_prod;
    logic [15:0] width;
    logic [15:0] start_pos;

    // The trailing edge is fixed by the discharge phase, so a wider pulse
    // means an earlier start inside the charge phase.
    assign width_prod = 19'(rif.charge_len) * 19'(rif.step);
    assign width      = width_prod[18:adfr_pkg::STEP_SHIFT];
    assign start_pos  = rif.charge_len - width;
    assign rif.allow  = (rif.step != adfr_pkg::STEP_NONE) &&
                        (rif.position >= start_pos);

endmodule : adfr_ramp

/* bench/adfr_osc.sv */
/*
 * Oscillator phase model that feeds the sequencer's phase input.
 * Assumes the bench clock; the phase changes on falling edges only.
 */
`timescale 1ns/1ps
module adfr_osc #(
    parameter int CHG = 40,
    parameter int DIS = 8
) (
    // Clock
    input  wire logic clk_in,
    // Oscillator phase
    output logic      discharge_phase_out
);
    int cnt_q = 0;

    initial discharge_phase_out = 1'b0;

    // The oscillator keeps running through faults, as the counts need it.
    always @(negedge clk_in) begin
        cnt_q <= (cnt_q == CHG + DIS - 1) ? 0 : cnt_q + 1;
        discharge_phase_out <= (cnt_q >= CHG - 1) && (cnt_q != CHG + DIS - 1);
    end
endmodule : adfr_osc

/* bench/adfr_top_test.sv */
/*
 * Self-checking bench of the alternating driver with fault retry.
 * Assumes the oscillator model in adfr_osc and a 200 MHz clock.
 */
`timescale 1ns/1ps
module adfr_top_test;
    localparam int CHG = 40;
    logic clk_in            = 1'b0;
    logic rst_n_in          = 1'b0;
    logic supply_lockout_in = 1'b0;
    logic over_current_in   = 1'b0;
    logic discharge_phase_in;
    logic drive_phase_a_out;
    logic drive_phase_b_out;
    logic sync_out;
    logic fault_off_out;
    int   n_mismatch = 0;
    int   compares   = 0;
    int   rises      = 0;
    int   first_sync = -1;
    int   np         = 0;
    int   wid        = 0;
    logic ph_q       = 1'b0;
    logic cur_b      = 1'b0;
    int   p_rise[16];
    int   p_wid[16];
    logic p_b[16];

    always #2.5 clk_in = ~clk_in;

    adfr_osc #(.CHG(CHG), .DIS(8)) i_osc (
        .clk_in              (clk_in),
        .discharge_phase_out (discharge_phase_in)
    );

    adfr_top i_dut (
        .clk_in             (clk_in),
        .rst_n_in           (rst_n_in),
        .supply_lockout_in  (supply_lockout_in),
        .over_current_in    (over_current_in),
        .discharge_phase_in (discharge_phase_in),
        .drive_phase_a_out  (drive_phase_a_out),
        .drive_phase_b_out  (drive_phase_b_out),
        .sync_out           (sync_out),
        .fault_off_out      (fault_off_out)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Tracks oscillator cycles since a fault and records the first 16 drive pulses.
    always @(negedge clk_in) begin
        logic rise;
        rise = discharge_phase_in && !ph_q;
        ph_q = discharge_phase_in;
        if (!rst_n_in || over_current_in || supply_lockout_in) begin
            rises = 0;
            np = 0;
            first_sync = -1;
            // A pulse cut by a fault is not recorded as a soft start pulse.
            wid = 0;
        end else if (rise) begin
            rises++;
        end
        check(sync_out && (drive_phase_a_out || drive_phase_b_out), 0);
        check(drive_phase_a_out && drive_phase_b_out, 0);
        check(fault_off_out, rises < 56);
        if (rises < 56)
            check(sync_out | drive_phase_a_out | drive_phase_b_out, 0);
        if (rises >= 58)
            check(sync_out, ph_q);
        if (sync_out && first_sync < 0)
            first_sync = rises;
        if (drive_phase_a_out || drive_phase_b_out) begin
            wid++;
            cur_b = drive_phase_b_out;
        end else if (wid > 0) begin
            check(rise, 1);
            if (np < 16) begin
                p_rise[np] = rises;
                p_wid[np] = wid;
                p_b[np] = cur_b;
                np++;
            end
            wid = 0;
        end
    end

    task automatic t_recover(input string name);
        int i;
        int kf;
        kf = -1;
        for (i = 0; i < 5000 && np < 9; i++) @(negedge clk_in);
        check(np >= 9, 1);
        check((p_rise[0] - 1) inside {[57:62]}, 1);
        check(first_sync inside {[56:57]}, 1);
        check(first_sync <= p_rise[0] - 2, 1);
        for (i = 0; i < 8; i++) begin
            check(p_b[i], i[0]);
            check(p_rise[i + 1], p_rise[i] + 1);
            if (kf < 0 && p_wid[i] >= CHG - 1)
                kf = i;
            if (kf < 0)
                check(p_wid[i] < p_wid[i + 1], 1);
        end
        check(kf inside {[4:7]}, 1);
        check(p_rise[kf], 64);
        $display("test %s done", name);
    endtask : t_recover

    task automatic t_overcurrent;
        int i;
        for (i = 0; i < 200 && !drive_phase_b_out; i++) @(negedge clk_in);
        check(drive_phase_b_out, 1);
        over_current_in <= 1'b1;
        #1;
        check(drive_phase_a_out | drive_phase_b_out | sync_out, 0);
        @(negedge clk_in);
        check(fault_off_out, 1);
        repeat (3) @(negedge clk_in);
        over_current_in <= 1'b0;
        t_recover("overcurrent");
    endtask : t_overcurrent

    task automatic t_lockout;
        int i;
        for (i = 0; i < 200 && !sync_out; i++) @(negedge clk_in);
        supply_lockout_in <= 1'b1;
        #1;
        check(sync_out | drive_phase_a_out | drive_phase_b_out, 0);
        repeat (4) @(negedge clk_in);
        supply_lockout_in <= 1'b0;
        // A short fault in mid soft start must restart the whole count.
        for (i = 0; i < 5000 && np < 2; i++) @(negedge clk_in);
        over_current_in <= 1'b1;
        @(negedge clk_in);
        over_current_in <= 1'b0;
        t_recover("lockout");
    endtask : t_lockout

    initial begin
        repeat (16) @(negedge clk_in);
        check(drive_phase_a_out | drive_phase_b_out | sync_out, 0);
        check(fault_off_out, 1);
        rst_n_in <= 1'b1;
        $display("test reset done");
        t_recover("start");
        t_overcurrent();
        t_lockout();
        end_of_test();
    end

    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule : adfr_top_test
